// file: dv/spp_far_model.sv
// far side: pin loads, external drivers and a one-byte spi slave
`timescale 1ns/1ps
`default_nettype none
module spp_far_model (
    // clock
    input wire logic aclk,
    // design pins
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_pullup,
    output logic [7:0] pin_in,
    // external drive and slave control
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    input wire logic slave_on,
    input wire logic load_en,
    input wire logic [7:0] load_val,
    input wire logic spi_shift_strobe,
    output logic [7:0] slave_data
);
    logic [7:0] drift = 8'h55;
    always @(posedge aclk) begin
        drift <= ~drift;
        if (load_en)
            slave_data <= load_val;
        else if (slave_on && spi_shift_strobe)
            slave_data <= {slave_data[6:0], pin_out[5]};
    end
    // a floating line must not look like a stable value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (slave_on && i == 4)
                pin_in[i] = slave_data[7];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pin_pullup[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = drift[i];
        end
    end
endmodule // spp_far_model
`default_nettype wire

// file: dv/spp_pin_ctrl_properties.sv
// port assertions for the serial port pin control block
`timescale 1ns/1ps
`default_nettype none
module spp_pin_ctrl_properties (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] pin_reduced_drive
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_reset_idle;
        $rose(aresetn) |-> pin_oe_n == 8'hff && pin_pullup == 8'h00;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pins not idle");
    property p_b_stand;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stand: assert property (p_b_stand) else $error("bvalid dropped");
    property p_r_stand;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_stand: assert property (p_r_stand) else $error("rvalid dropped");
    property p_ar_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_refuse: assert property (p_ar_refuse) else $error("arready early");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("no read answer");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {32'h340,
            32'h34c, 32'h354, 32'h358, 32'h35c, 32'h364, 32'h380})
            |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read ok");
    property p_pullup_out;
        (pin_pullup & ~pin_oe_n) == 8'h00;
    endproperty
    a_pullup_out: assert property (p_pullup_out) else $error("pullup on out");
    property p_drive_group;
        pin_reduced_drive[7:4] inside {4'h0, 4'hf} &&
            pin_reduced_drive[3] == pin_reduced_drive[2] &&
            pin_reduced_drive[1] == pin_reduced_drive[0];
    endproperty
    a_drive_group: assert property (p_drive_group) else $error("split group");
endmodule // spp_pin_ctrl_properties
bind spp_pin_ctrl spp_pin_ctrl_properties u_spp_pin_ctrl_properties (.aclk,
    .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pin_oe_n, .pin_pullup, .pin_reduced_drive);
`default_nettype wire

// file: dv/test_serial_port_pin_control.sv
// self-checking bench for the serial port pin control block
`timescale 1ns/1ps
`default_nettype none
`include "spp_map.vh"
module test_serial_port_pin_control;
    localparam logic [7:0] i_ctl = `SPP_IDX_CTRL_ONE;
    localparam logic [7:0] i_st = `SPP_IDX_STATUS;
    localparam logic [7:0] i_dat = `SPP_IDX_SHIFT_DATA;
    localparam logic [7:0] i_lat = `SPP_IDX_PIN_LATCH;
    localparam logic [7:0] i_dir = `SPP_IDX_DIRECTION;
    localparam logic [7:0] i_pad = `SPP_IDX_PAD_CTRL;
    localparam logic [7:0] i_asy = `SPP_IDX_ASYNC_CFG;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic spi_shift_strobe = 1'b0;
    logic spi_sck_drive = 1'b1;
    logic spi_busy = 1'b0;
    logic async_tx0_drive = 1'b1;
    logic async_tx1_drive = 1'b0;
    logic [7:0] ext_val = 8'hbc;
    logic [7:0] ext_en = 8'hff;
    logic slave_on = 1'b0;
    logic load_en = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, spi_serial_in;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] pin_in, pin_out, pin_oe_n, pin_pullup, pin_reduced_drive;
    logic [7:0] slave_data;
    int n_mismatch = 0;
    int checks_done = 0;
    always #4 aclk = ~aclk;
    spp_pin_ctrl u_spp_pin_ctrl (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe_n,
        .pin_pullup, .pin_reduced_drive, .spi_shift_strobe, .spi_sck_drive,
        .spi_busy, .spi_serial_in, .async_tx0_drive, .async_tx1_drive);
    spp_far_model u_spp_far_model (.aclk, .pin_out, .pin_oe_n, .pin_pullup,
        .pin_in, .ext_val, .ext_en, .slave_on, .load_en, .load_val(8'h5a),
        .spi_shift_strobe, .slave_data);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // lag holds back bready so a pending response has to stand
    task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                      input logic [1:0] er = 2'h0, input int lag = 0);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= {22'h0, idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (lag == 0);
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            n++;
            if (n >= lag) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                      input logic [1:0] er = 2'h0, input int lag = 0);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= {22'h0, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (lag == 0);
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            n++;
            if (n >= lag) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        check("rdata", exp, s_axi_rdata);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        check("oe", 32'hff, {24'h0, pin_oe_n});
        rd(i_dir, 32'h00);
        rd(i_ctl, 32'h04);
        rd(i_pad, 32'h00, 2'h0, 3);
        rd(i_lat, 32'hbc);
        rd(8'h10, 32'h0, 2'h2);
        wr(8'h10, 32'h1, 2'h2);
        wr(i_lat, 32'ha5);
        check("oe", 32'hff, {24'h0, pin_oe_n});
        wr(i_dir, 32'hf0);
        check("oe", 32'h0f, {24'h0, pin_oe_n});
        check("out", 32'ha0, {24'h0, pin_out & 8'hf0});
        rd(i_lat, 32'hac);
        ext_en <= 8'hfc;
        wr(i_pad, 32'h25, 2'h0, 2);
        check("pullup", 32'h03, {24'h0, pin_pullup});
        check("drive", 32'h0c, {24'h0, pin_reduced_drive});
        rd(i_lat, 32'haf);
        ext_en <= 8'hff;
        wr(i_pad, 32'h52);
        check("pullup", 32'h0c, {24'h0, pin_pullup});
        check("drive", 32'hf3, {24'h0, pin_reduced_drive});
        wr(i_dir, 32'h05);
        wr(i_asy, 32'h0f);
        check("oe", 32'hf5, {24'h0, pin_oe_n});
        wr(i_lat, 32'h00);
        check("tx", 32'h1, {30'h0, pin_out[3], pin_out[1]});
        wr(i_asy, 32'h00);
        // fault: master, pins 5 and 6 out, select pin pulled low
        wr(i_dir, 32'h60);
        wr(i_ctl, 32'h50);
        check("sck", 32'h1, {31'h0, pin_out[6] & ~pin_oe_n[6]});
        ext_val <= 8'h3c;
        rd(i_dir, 32'h00);
        check("oe", 32'hff, {24'h0, pin_oe_n});
        rd(i_ctl, 32'h10);
        ext_val <= 8'hbc;
        wr(i_ctl, 32'h50);
        rd(i_st, 32'h10);
        wr(i_ctl, 32'h50);
        rd(i_st, 32'h00);
        wr(i_dir, 32'h80);
        ext_val <= 8'h3c;
        rd(i_st, 32'h00);
        check("p7", 32'h0, {31'h0, pin_out[7] | pin_oe_n[7]});
        wr(i_ctl, 32'h52);
        spi_busy <= 1'b1;
        @(posedge aclk);
        check("sel", 32'h0, {31'h0, pin_out[7] | pin_oe_n[7]});
        spi_busy <= 1'b0;
        @(posedge aclk);
        check("sel", 32'h1, {31'h0, pin_out[7]});
        wr(i_ctl, 32'h40);
        wr(i_dir, 32'h90);
        check("oe", 32'hef, {24'h0, pin_oe_n});
        check("sdi", 32'h1, {31'h0, spi_serial_in});
        ext_val <= 8'hbc;
        wr(i_ctl, 32'h40);
        check("oe", 32'hff, {24'h0, pin_oe_n});
        // one byte exchanged with the slave model
        wr(i_ctl, 32'h50);
        wr(i_dir, 32'h20);
        load_en <= 1'b1;
        @(posedge aclk);
        load_en <= 1'b0;
        slave_on <= 1'b1;
        wr(i_dat, 32'hc3);
        check("mosi", 32'h1, {31'h0, pin_out[5]});
        check("sdi", 32'h0, {31'h0, spi_serial_in});
        repeat (8) begin
            @(posedge aclk);
            spi_shift_strobe <= 1'b1;
            @(posedge aclk);
            spi_shift_strobe <= 1'b0;
        end
        rd(i_st, 32'h80);
        rd(i_dat, 32'h5a);
        check("slave", 32'hc3, {24'h0, slave_data});
        wr(i_dat, 32'h11);
        rd(i_dat, 32'h5a);
        // mid-run reset: pins go idle, read buffer survives
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        check("oe", 32'hff, {24'h0, pin_oe_n});
        rd(i_dat, 32'h5a);
        rd(i_ctl, 32'h04);
        stop_test;
    end
endmodule // test_serial_port_pin_control
`default_nettype wire

// file: hdl/spp_map.vh
// register indices, field positions and reset values of the pin control block
`ifndef SPP_MAP_VH
`define SPP_MAP_VH

// register indices; byte address is four times the index
`define SPP_IDX_CTRL_ONE 8'hd0
`define SPP_IDX_STATUS 8'hd3
`define SPP_IDX_SHIFT_DATA 8'hd5
`define SPP_IDX_PIN_LATCH 8'hd6
`define SPP_IDX_DIRECTION 8'hd7
`define SPP_IDX_PAD_CTRL 8'hd9
`define SPP_IDX_ASYNC_CFG 8'he0

// spi_control_one fields
`define SPP_C1_SYS_EN 6
`define SPP_C1_MASTER 4
`define SPP_C1_SEL_OE 1

// spi_status_reg fields
`define SPP_SR_DONE 7
`define SPP_SR_MODE_FAULT 4

// serial_port_pad_control fields
`define SPP_PAD_PU_LOWER 0
`define SPP_PAD_PU_MIDDLE 1
`define SPP_PAD_PU_UPPER 2
`define SPP_PAD_RD_LOWER 4
`define SPP_PAD_RD_MIDDLE 5
`define SPP_PAD_RD_UPPER 6

// async serial two-wire configuration fields
`define SPP_AC_RX0 0
`define SPP_AC_TX0 1
`define SPP_AC_RX1 2
`define SPP_AC_TX1 3

// reset values
`define SPP_RST_CTRL_ONE 8'h04
`define SPP_RST_DIRECTION 8'h00
`define SPP_RST_LATCH 8'h00
`define SPP_RST_PAD 8'h00
`define SPP_RST_ASYNC 4'h0

// bits shifted per spi transfer
`define SPP_SHIFT_BITS 4'h8

`endif

// file: hdl/spp_pin_ctrl.v
// serial port pin control: gpio port shared with spi and two async units
`timescale 1ns/1ps
`default_nettype none
`include "spp_map.vh"

module spp_pin_ctrl (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [31:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [31:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // port pins
    input wire [7:0] pin_in,
    output wire [7:0] pin_out,
    output wire [7:0] pin_oe_n,
    output wire [7:0] pin_pullup,
    output wire [7:0] pin_reduced_drive,
    // spi clock generator side
    input wire spi_shift_strobe,
    input wire spi_sck_drive,
    input wire spi_busy,
    output wire spi_serial_in,
    // async serial units
    input wire async_tx0_drive,
    input wire async_tx1_drive
);

////////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] ctrl_one;
reg [7:0] serial_port_direction;
reg [7:0] serial_port_pin_latch;
reg [7:0] serial_port_pad_control;
reg [3:0] async_cfg;
reg mode_fault_flag;
reg fault_clear_armed;
reg done_flag;
reg done_clear_armed;
reg [7:0] spi_shift_data;
reg [7:0] read_buffer;
reg [3:0] shift_count;

reg aw_held;
reg w_held;
reg [7:0] aw_index;
reg [7:0] w_data;
reg w_lane0;

wire spi_system_enable;
wire master_select;
wire select_output_enable;
wire dir_bit_seven;
wire dir_bit_four;
wire select_in_low;

// a latched fault keeps the spi off its pins until recovered
assign spi_system_enable = ctrl_one[`SPP_C1_SYS_EN] & ~mode_fault_flag;
assign master_select = ctrl_one[`SPP_C1_MASTER];
assign select_output_enable = ctrl_one[`SPP_C1_SEL_OE];
assign dir_bit_seven = serial_port_direction[7];
assign dir_bit_four = serial_port_direction[4];
assign select_in_low = ~pin_in[7];

////////////////////////////////////////////////////////////////////////////////
// pin ownership and drive

reg [7:0] own_oe;
reg [7:0] own_val;
reg [7:0] claimed_out;

always @* begin
    // plain gpio by default
    own_oe = serial_port_direction;
    own_val = serial_port_pin_latch;
    claimed_out = 8'h00;
    if (async_cfg[`SPP_AC_RX0]) begin
        own_oe[0] = 1'b0;
    end
    if (async_cfg[`SPP_AC_RX1]) begin
        own_oe[2] = 1'b0;
    end
    if (async_cfg[`SPP_AC_TX0]) begin
        own_oe[1] = 1'b1;
        own_val[1] = async_tx0_drive;
        claimed_out[1] = 1'b1;
    end
    if (async_cfg[`SPP_AC_TX1]) begin
        own_oe[3] = 1'b1;
        own_val[3] = async_tx1_drive;
        claimed_out[3] = 1'b1;
    end
    if (spi_system_enable) begin
        if (master_select) begin
            own_oe[4] = 1'b0;
            own_oe[5] = serial_port_direction[5];
            own_val[5] = spi_shift_data[7];
            claimed_out[5] = 1'b1;
            own_oe[6] = serial_port_direction[6];
            own_val[6] = spi_sck_drive;
            claimed_out[6] = 1'b1;
            if (dir_bit_seven && select_output_enable) begin
                own_oe[7] = 1'b1;
                own_val[7] = ~spi_busy;
                claimed_out[7] = 1'b1;
            end else if (dir_bit_seven) begin
                own_oe[7] = 1'b1;
            end else begin
                own_oe[7] = 1'b0;
            end
        end else begin
            own_oe[4] = dir_bit_four & select_in_low;
            own_val[4] = spi_shift_data[7];
            claimed_out[4] = 1'b1;
            own_oe[5] = 1'b0;
            own_oe[6] = 1'b0;
            own_oe[7] = 1'b0;
        end
    end
end

assign pin_out = own_val;
assign pin_oe_n = ~own_oe;

// pad controls per group; outputs never pull up
genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : pad_gen
        localparam integer PU_BIT = (g >= 4) ? `SPP_PAD_PU_UPPER :
            (g >= 2) ? `SPP_PAD_PU_MIDDLE : `SPP_PAD_PU_LOWER;
        localparam integer RD_BIT = (g >= 4) ? `SPP_PAD_RD_UPPER :
            (g >= 2) ? `SPP_PAD_RD_MIDDLE : `SPP_PAD_RD_LOWER;
        assign pin_pullup[g] = serial_port_pad_control[PU_BIT] &
            ~own_oe[g];
        assign pin_reduced_drive[g] = serial_port_pad_control[RD_BIT];
    end
endgenerate

// master samples its data-in pin, slave the other one
assign spi_serial_in = master_select ? pin_in[4] : pin_in[5];

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

wire do_write;
wire ar_take;
wire write_ok;
wire read_ok;
wire [7:0] ar_index;
reg [7:0] rd_val;

assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready = ~w_held & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;
assign do_write = aw_held & w_held & ~s_axi_bvalid;
assign ar_take = s_axi_arvalid & s_axi_arready;
assign ar_index = s_axi_araddr[9:2];

assign write_ok = (aw_index == `SPP_IDX_CTRL_ONE) ||
    (aw_index == `SPP_IDX_STATUS) ||
    (aw_index == `SPP_IDX_SHIFT_DATA) ||
    (aw_index == `SPP_IDX_PIN_LATCH) ||
    (aw_index == `SPP_IDX_DIRECTION) ||
    (aw_index == `SPP_IDX_PAD_CTRL) ||
    (aw_index == `SPP_IDX_ASYNC_CFG);
assign read_ok = (ar_index == `SPP_IDX_CTRL_ONE) ||
    (ar_index == `SPP_IDX_STATUS) ||
    (ar_index == `SPP_IDX_SHIFT_DATA) ||
    (ar_index == `SPP_IDX_PIN_LATCH) ||
    (ar_index == `SPP_IDX_DIRECTION) ||
    (ar_index == `SPP_IDX_PAD_CTRL) ||
    (ar_index == `SPP_IDX_ASYNC_CFG);

always @* begin
    rd_val = 8'h00;
    if (ar_index == `SPP_IDX_CTRL_ONE) begin
        rd_val = ctrl_one;
        rd_val[`SPP_C1_SYS_EN] = spi_system_enable;
    end else if (ar_index == `SPP_IDX_STATUS) begin
        rd_val[`SPP_SR_DONE] = done_flag;
        rd_val[`SPP_SR_MODE_FAULT] = mode_fault_flag;
    end else if (ar_index == `SPP_IDX_SHIFT_DATA) begin
        rd_val = read_buffer;
    end else if (ar_index == `SPP_IDX_PIN_LATCH) begin
        rd_val = (own_oe & own_val) | (~own_oe & pin_in);
    end else if (ar_index == `SPP_IDX_DIRECTION) begin
        rd_val = serial_port_direction;
    end else if (ar_index == `SPP_IDX_PAD_CTRL) begin
        rd_val = serial_port_pad_control;
    end else if (ar_index == `SPP_IDX_ASYNC_CFG) begin
        rd_val = {4'h0, async_cfg};
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_index <= 8'h00;
        w_data <= 8'h00;
        w_lane0 <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= 2'h0;
        s_axi_rdata <= 32'h00000000;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_index <= s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= write_ok ? 2'h0 : 2'h2;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= read_ok ? 2'h0 : 2'h2;
            s_axi_rdata <= {24'h000000, rd_val};
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// control registers and flags

wire wr_en;
wire wr_ctrl_one;
wire wr_data;
wire rd_status;
wire rd_data;
wire fault_now;
wire transfer_done;

assign wr_en = do_write & w_lane0;
assign wr_ctrl_one = wr_en & (aw_index == `SPP_IDX_CTRL_ONE);
assign wr_data = wr_en & (aw_index == `SPP_IDX_SHIFT_DATA);
assign rd_status = ar_take & (ar_index == `SPP_IDX_STATUS);
assign rd_data = ar_take & (ar_index == `SPP_IDX_SHIFT_DATA);
assign fault_now = ctrl_one[`SPP_C1_SYS_EN] & master_select &
    ~dir_bit_seven & select_in_low;
assign transfer_done = spi_shift_strobe &
    (shift_count == `SPP_SHIFT_BITS - 4'h1);

always @(posedge aclk) begin
    if (!aresetn) begin
        ctrl_one <= `SPP_RST_CTRL_ONE;
        serial_port_direction <= `SPP_RST_DIRECTION;
        serial_port_pin_latch <= `SPP_RST_LATCH;
        serial_port_pad_control <= `SPP_RST_PAD;
        async_cfg <= `SPP_RST_ASYNC;
        mode_fault_flag <= 1'b0;
        fault_clear_armed <= 1'b0;
        done_flag <= 1'b0;
        done_clear_armed <= 1'b0;
        shift_count <= 4'h0;
    end else begin
        if (wr_ctrl_one) begin
            ctrl_one <= w_data;
        end
        if (wr_en && aw_index == `SPP_IDX_PIN_LATCH) begin
            serial_port_pin_latch <= w_data;
        end
        if (wr_en && aw_index == `SPP_IDX_PAD_CTRL) begin
            serial_port_pad_control <= w_data;
        end
        if (wr_en && aw_index == `SPP_IDX_ASYNC_CFG) begin
            async_cfg <= w_data[3:0];
        end
        // fault forcing of bits 7:5 wins over a same-cycle direction write; bits 4:0 still take it
        if (fault_now) begin
            serial_port_direction[7:5] <= 3'h0;
            serial_port_direction[4:0] <= (wr_en &&
                aw_index == `SPP_IDX_DIRECTION) ? w_data[4:0] :
                serial_port_direction[4:0];
        end else if (wr_en && aw_index == `SPP_IDX_DIRECTION) begin
            serial_port_direction <= w_data;
        end
        // set wins over the recovery clear
        if (dir_bit_seven) begin
            mode_fault_flag <= 1'b0;
            fault_clear_armed <= 1'b0;
        end else if (fault_now) begin
            mode_fault_flag <= 1'b1;
        end else if (wr_ctrl_one && fault_clear_armed) begin
            mode_fault_flag <= 1'b0;
            fault_clear_armed <= 1'b0;
        end else if (rd_status && mode_fault_flag) begin
            fault_clear_armed <= 1'b1;
        end
        // transfer count; a data write restarts it
        if (wr_data) begin
            shift_count <= 4'h0;
        end else if (transfer_done) begin
            shift_count <= 4'h0;
        end else if (spi_shift_strobe) begin
            shift_count <= shift_count + 4'h1;
        end
        if (transfer_done) begin
            done_flag <= 1'b1;
        end else if ((rd_data || wr_data) && done_clear_armed) begin
            done_flag <= 1'b0;
            done_clear_armed <= 1'b0;
        end else if (rd_status && done_flag) begin
            done_clear_armed <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// spi data path, never reset so contents survive a reset

always @(posedge aclk) begin
    if (wr_data) begin
        spi_shift_data <= w_data;
    end else if (spi_shift_strobe) begin
        spi_shift_data <= {spi_shift_data[6:0], spi_serial_in};
    end
    if (transfer_done) begin
        read_buffer <= {spi_shift_data[6:0], spi_serial_in};
    end
end

endmodule // spp_pin_ctrl

`default_nettype wire
